/* File: rtl/lrsd_pkg.sv */
// Operation
// - Output-control frames accepted only on the strap-derived identifier
// - Even addresses 0x60..0x6C each own eight identifiers; others decode none
// - Get-status header with our identifier gets an eight-byte response
// - First byte: error code in bits 7:5, application info in 4:0
// - Stored error code is cleared by sending a response containing it
// - Error codes 0..7, higher value wins, highest pending is reported
// - Bytes two and three carry eight two-bit channel states, four each, low first
// - Response bytes four to eight are always zero
// - Open load and local overtemperature only on outputs four and eight
// - Channel state: 00 open load, 01 off, 10 on, 11 latched
// - App info 00000 none, 00100 global shutdown, 01000 out4/8 fault
// - Unsupported application info bit patterns are never sent
// - Status identifier from address and slave position A to D
// - Protected identifier: id in 5:0, even parity bit 6, odd bit 7
// - Channel command 01 off, 10 on, 00 and 11 no change
package lrsd_pkg;
    localparam logic [7:0] NAD_BASE = 8'h60;
    localparam logic [7:0] NAD_LAST = 8'h6C;
    localparam logic [2:0] CTRL_SUB = 3'h1;
    localparam logic [2:0] STAT_SUB = 3'h2;
    localparam logic [3:0] LAST_BYTE = 4'h8;
    localparam logic [2:0] ERR_NONE = 3'h0;
    localparam logic [2:0] ERR_RESET = 3'h1;
    localparam logic [2:0] ERR_DATA = 3'h4;
    localparam logic [2:0] ERR_CKSUM = 3'h5;
    localparam logic [2:0] ERR_FRAME = 3'h6;
    localparam logic [2:0] ERR_PARITY = 3'h7;
    localparam logic [4:0] APP_NONE = 5'h00;
    localparam logic [4:0] APP_GLOBAL_TSD = 5'h04;
    localparam logic [4:0] APP_OUT48 = 5'h08;
    localparam logic [1:0] ST_OPEN = 2'h0;
    localparam logic [1:0] ST_OFF = 2'h1;
    localparam logic [1:0] ST_ON = 2'h2;
    localparam logic [1:0] ST_LATCHED = 2'h3;
    localparam logic [1:0] CMD_OFF = 2'h1;
    localparam logic [1:0] CMD_ON = 2'h2;
    localparam logic [7:0] CKSUM_OK = 8'hFF;
    localparam logic [11:0] REG_IRQ_STAT = 12'h000;
    localparam logic [11:0] REG_IRQ_MASK = 12'h004;
    localparam logic [11:0] REG_INFO = 12'h008;
    localparam logic [11:0] REG_CHAN = 12'h00C;
    localparam logic [11:0] REG_CTRL = 12'h010;
    localparam int IRQ_ERR = 0;
    localparam int IRQ_CTRL = 1;
    localparam int IRQ_STAT = 2;
    localparam int IRQ_LATCH = 3;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;
    localparam logic CTRL_RESP_EN_RST = 1'b1;

    typedef struct packed {
        logic [7:0] overcurrent;
        logic [1:0] open_load;
        logic [1:0] local_ot;
        logic global_tsd;
    } lrsd_fault_s;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } lrsd_byte_s;

    typedef enum {ST_IDLE, ST_RX_CTRL, ST_TX_STAT} lrsd_state_e;

    function automatic logic [7:0] lrsd_pid(input logic [5:0] id);
        lrsd_pid = {~(id[1] ^ id[3] ^ id[4] ^ id[5]),
                    id[0] ^ id[1] ^ id[2] ^ id[4], id};
    endfunction

    function automatic logic [7:0] lrsd_add(input logic [7:0] a,
                                            input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        lrsd_add = s[7:0] + {7'h00, s[8]};
    endfunction

    function automatic logic [2:0] lrsd_max(input logic [2:0] a,
                                            input logic [2:0] b);
        lrsd_max = (a > b) ? a : b;
    endfunction
endpackage

/* File: rtl/lrsd_decoder.sv */
`timescale 1ns/1ps
module lrsd_decoder (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // APB slave
    input wire logic apb_psel_in,
    input wire logic apb_penable_in,
    input wire logic apb_pwrite_in,
    input wire logic [11:0] apb_paddr_in,
    input wire logic [31:0] apb_pwdata_in,
    output logic apb_pready_out,
    output logic [31:0] apb_prdata_out,
    output logic apb_pslverr_out,
    // Straps
    input wire logic [7:0] node_address_in,
    input wire logic [1:0] slave_position_select_in,
    // Frame layer
    input wire logic hdr_valid_in,
    input wire logic [7:0] hdr_pid_in,
    input wire lrsd_pkg::lrsd_byte_s rx_byte_in,
    input wire logic rx_abort_in,
    input wire logic rx_framing_err_in,
    output logic tx_valid_out,
    output logic [7:0] tx_byte_out,
    input wire logic tx_ready_in,
    // Drivers and fault detectors
    input wire lrsd_pkg::lrsd_fault_s fault_in,
    output logic [7:0] channel_on_out,
    output logic irq_out
);
    import lrsd_pkg::*;

    // ------------------------------------------------------------
    // Strap capture and identifier decode
    // ------------------------------------------------------------
    logic cap_r;
    logic [7:0] nad_r;
    logic [1:0] pos_r;
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            cap_r <= 1'b0;
            nad_r <= 8'h00;
            pos_r <= 2'h0;
        end else if (!cap_r) begin
            cap_r <= 1'b1;
            nad_r <= node_address_in;
            pos_r <= slave_position_select_in;
        end
    end

    wire [7:0] nad_off = nad_r - NAD_BASE;
    wire addr_ok = cap_r && !nad_r[0] && nad_r >= NAD_BASE
                   && nad_r <= NAD_LAST;
    wire [2:0] grp = nad_off[3:1];
    wire [7:0] ctrl_pid = lrsd_pid({grp, CTRL_SUB});
    wire [5:0] stat_id = {grp, STAT_SUB + {1'b0, pos_r}};
    wire [7:0] stat_pid = lrsd_pid(stat_id);
    wire pid_bad = hdr_valid_in && hdr_pid_in != lrsd_pid(hdr_pid_in[5:0]);
    wire hdr_ok = hdr_valid_in && !pid_bad && addr_ok;
    wire hit_ctrl = hdr_ok && hdr_pid_in == ctrl_pid;
    logic resp_en_r;
    wire hit_stat = hdr_ok && resp_en_r && hdr_pid_in == stat_pid;

    // ------------------------------------------------------------
    // Frame state
    // ------------------------------------------------------------
    lrsd_state_e state_r, state_nxt;
    logic [3:0] cnt_r;
    logic [7:0] acc_r;
    logic [15:0] cmd_r;
    wire rx_take = state_r == ST_RX_CTRL && rx_byte_in.valid;
    wire rx_last = rx_take && cnt_r == LAST_BYTE;
    wire [7:0] acc_add = lrsd_add(acc_r, rx_byte_in.data);
    wire ck_good = acc_add == CKSUM_OK;
    wire apply = rx_last && ck_good;
    wire tx_hs = tx_valid_out && tx_ready_in;
    wire tx_end = state_r == ST_TX_STAT && tx_hs && cnt_r == LAST_BYTE;
    wire my_lo = rx_take && cnt_r == {1'b0, pos_r, 1'b0};
    wire my_hi = rx_take && cnt_r == {1'b0, pos_r, 1'b1};

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: state_nxt = ST_IDLE;
            ST_RX_CTRL: if (rx_last || rx_abort_in) state_nxt = ST_IDLE;
            ST_TX_STAT: if (tx_end) state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
        if (hit_ctrl) begin
            state_nxt = ST_RX_CTRL;
        end else if (hit_stat) begin
            state_nxt = ST_TX_STAT;
        end else if (hdr_valid_in) begin
            state_nxt = ST_IDLE;
        end
    end

    // ------------------------------------------------------------
    // Error code
    // ------------------------------------------------------------
    logic [2:0] err_r;
    wire [2:0] ev_parity = pid_bad ? ERR_PARITY : ERR_NONE;
    wire [2:0] ev_frame = rx_framing_err_in ? ERR_FRAME : ERR_NONE;
    wire [2:0] ev_ck = (rx_last && !ck_good) ? ERR_CKSUM : ERR_NONE;
    wire [2:0] ev_data = (state_r == ST_RX_CTRL && rx_abort_in) ?
                         ERR_DATA : ERR_NONE;
    wire [2:0] err_ev = lrsd_max(lrsd_max(ev_parity, ev_frame),
                                 lrsd_max(ev_ck, ev_data));
    wire [2:0] err_nxt = hit_stat ? err_ev :
                         lrsd_max(err_r, err_ev);

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    logic [7:0] on_r;
    logic [7:0] latch_r;
    logic [7:0] on_nxt, latch_nxt, chfault;
    logic [15:0] pairs;
    // Both command bytes are held before the checksum byte arrives
    wire [15:0] cmd_use = cmd_r;

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            chfault[i] = fault_in.overcurrent[i];
            on_nxt[i] = on_r[i];
            latch_nxt[i] = latch_r[i];
            if (apply && cmd_use[2*i +: 2] == CMD_OFF) begin
                on_nxt[i] = 1'b0;
                latch_nxt[i] = 1'b0;
            end else if (apply && cmd_use[2*i +: 2] == CMD_ON) begin
                on_nxt[i] = 1'b1;
                latch_nxt[i] = 1'b0;
            end
            if (fault_in.global_tsd) begin
                on_nxt[i] = 1'b0;
            end
        end
        chfault[3] = fault_in.overcurrent[3] | fault_in.local_ot[0];
        chfault[7] = fault_in.overcurrent[7] | fault_in.local_ot[1];
        for (int i = 0; i < 8; i++) begin
            if (on_r[i] && !latch_r[i] && chfault[i]) begin
                latch_nxt[i] = 1'b1;
            end
        end
        for (int i = 0; i < 8; i++) begin
            if (latch_r[i]) begin
                pairs[2*i +: 2] = ST_LATCHED;
            end else if (on_r[i]) begin
                pairs[2*i +: 2] = ST_ON;
            end else begin
                pairs[2*i +: 2] = ST_OFF;
            end
        end
        if (!on_r[3] && !latch_r[3] && fault_in.open_load[0]) begin
            pairs[7:6] = ST_OPEN;
        end
        if (!on_r[7] && !latch_r[7] && fault_in.open_load[1]) begin
            pairs[15:14] = ST_OPEN;
        end
    end
    wire latch_ev = |(latch_nxt & ~latch_r);
    wire [4:0] app = fault_in.global_tsd ? APP_GLOBAL_TSD :
                     (latch_r[3] || latch_r[7]) ? APP_OUT48 :
                     APP_NONE;

    // ------------------------------------------------------------
    // Response image
    // ------------------------------------------------------------
    logic [7:0] resp_r [0:8];
    logic [7:0] resp_w [0:8];
    logic [7:0] ck;
    always_comb begin
        resp_w[0] = {err_r, app};
        resp_w[1] = pairs[7:0];
        resp_w[2] = pairs[15:8];
        for (int k = 3; k < 8; k++) begin
            resp_w[k] = 8'h00;
        end
        ck = hdr_pid_in;
        for (int k = 0; k < 8; k++) begin
            ck = lrsd_add(ck, resp_w[k]);
        end
        resp_w[8] = ~ck;
    end
    wire [3:0] cnt_inc = cnt_r + 4'h1;
    wire [7:0] tx_byte_nxt = hit_stat ? resp_w[0] :
                             (tx_hs && cnt_r < LAST_BYTE) ?
                             resp_r[cnt_inc] : tx_byte_out;
    wire tx_valid_nxt = hit_stat ||
                        (state_r == ST_TX_STAT && !tx_end && !hdr_valid_in);

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            state_r <= ST_IDLE;
            cnt_r <= 4'h0;
            acc_r <= 8'h00;
            cmd_r <= 16'h0000;
            err_r <= ERR_RESET;
            on_r <= 8'h00;
            latch_r <= 8'h00;
            tx_valid_out <= 1'b0;
            tx_byte_out <= 8'h00;
            channel_on_out <= 8'h00;
        end else begin
            state_r <= state_nxt;
            err_r <= err_nxt;
            on_r <= on_nxt;
            latch_r <= latch_nxt;
            channel_on_out <= on_nxt & ~latch_nxt;
            tx_valid_out <= tx_valid_nxt;
            tx_byte_out <= tx_byte_nxt;
            if (hit_ctrl || hit_stat) begin
                cnt_r <= 4'h0;
                acc_r <= hdr_pid_in;
            end else if (rx_take || tx_hs) begin
                cnt_r <= cnt_inc;
                acc_r <= acc_add;
            end
            if (my_lo) begin
                cmd_r[7:0] <= rx_byte_in.data;
            end
            if (my_hi) begin
                cmd_r[15:8] <= rx_byte_in.data;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (hit_stat) begin
            resp_r <= resp_w;
        end
    end

    // ------------------------------------------------------------
    // APB registers and interrupt
    // ------------------------------------------------------------
    logic [3:0] irq_stat_r, irq_mask_r;
    wire apb_setup = apb_psel_in && !apb_penable_in;
    wire apb_wr = apb_psel_in && apb_penable_in && apb_pwrite_in
                  && apb_pready_out;
    wire sel_stat = apb_paddr_in == REG_IRQ_STAT;
    wire sel_mask = apb_paddr_in == REG_IRQ_MASK;
    wire sel_info = apb_paddr_in == REG_INFO;
    wire sel_chan = apb_paddr_in == REG_CHAN;
    wire sel_ctrl = apb_paddr_in == REG_CTRL;
    wire mapped = sel_stat | sel_mask | sel_info | sel_chan | sel_ctrl;
    wire [31:0] rd_mux = sel_stat ? {28'h0, irq_stat_r} :
                         sel_mask ? {28'h0, irq_mask_r} :
                         sel_info ? {14'h0, pos_r, nad_r, err_r, app} :
                         sel_chan ? {16'h0, pairs} :
                         sel_ctrl ? {31'h0, resp_en_r} : 32'h0;
    wire [3:0] irq_ev = {latch_ev, tx_end, apply, err_ev != ERR_NONE};
    wire [3:0] w1c = (apb_wr && sel_stat) ? apb_pwdata_in[3:0] : 4'h0;
    wire [3:0] irq_stat_nxt = (irq_stat_r & ~w1c) | irq_ev;

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            irq_stat_r <= 4'h0;
            irq_mask_r <= IRQ_MASK_RST;
            resp_en_r <= CTRL_RESP_EN_RST;
            irq_out <= 1'b0;
            apb_pready_out <= 1'b0;
            apb_prdata_out <= 32'h0;
            apb_pslverr_out <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            irq_out <= |(irq_stat_nxt & irq_mask_r);
            apb_pready_out <= apb_setup;
            apb_pslverr_out <= apb_setup && !mapped;
            apb_prdata_out <= (apb_setup && !apb_pwrite_in) ? rd_mux : 32'h0;
            if (apb_wr && sel_mask) begin
                irq_mask_r <= apb_pwdata_in[3:0];
            end
            if (apb_wr && sel_ctrl) begin
                resp_en_r <= apb_pwdata_in[0];
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_ctrl_accept: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (hdr_valid_in && addr_ok && hdr_pid_in == lrsd_pid({grp, CTRL_SUB}))
        |=> state_r == ST_RX_CTRL)
        else $error("control header not accepted");
    a_bad_addr: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (cap_r && !addr_ok) |-> state_r == ST_IDLE && !tx_valid_out)
        else $error("unsupported address decoded a frame");
    a_stat_len: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (hit_stat ##1 (tx_ready_in && !hdr_valid_in) [*8])
        |=> tx_valid_out && cnt_r == LAST_BYTE)
        else $error("status response length wrong");
    a_err_clear: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (hit_stat && err_ev == ERR_NONE)
        |=> err_r == ERR_NONE && resp_r[0][7:5] == $past(err_r))
        else $error("error code not cleared by readout");
    a_err_prio: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (!hit_stat && err_ev <= err_r) |=> $stable(err_r))
        else $error("lower error overwrote held code");
    a_zero_tail: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (state_r == ST_TX_STAT && cnt_r >= 4'h3 && cnt_r < LAST_BYTE)
        |-> tx_byte_out == 8'h00)
        else $error("tail byte not zero");
    a_app_legal: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (state_r == ST_TX_STAT && cnt_r == 4'h0)
        |-> !tx_byte_out[4] && tx_byte_out[1:0] == 2'h0
            && tx_byte_out[3:2] != 2'h3)
        else $error("unsupported application info sent");
    a_latch_pair: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (on_r[0] && !latch_r[0] && fault_in.overcurrent[0])
        |=> pairs[1:0] == ST_LATCHED && !channel_on_out[0])
        else $error("overcurrent did not latch channel");
    a_open_only48: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        pairs[1:0] != ST_OPEN && pairs[9:8] != ST_OPEN)
        else $error("open load reported on wrong channel");
    a_cmd_on: assert property (@(posedge core_clk_in)
        disable iff (!rst_n_in)
        (apply && cmd_use[1:0] == CMD_ON && !fault_in.global_tsd)
        |=> on_r[0] ##1 pairs[1:0] != ST_OFF)
        else $error("on command not applied");
endmodule

/* File: verification/lrsd_lin_master.sv */
`timescale 1ns/1ps
module lrsd_lin_master (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    // Bench control
    input wire logic slow_in,
    // Frame layer
    output logic hdr_valid_out,
    output logic [7:0] hdr_pid_out,
    output lrsd_pkg::lrsd_byte_s rx_byte_out,
    output logic rx_abort_out,
    output logic rx_framing_err_out,
    input wire logic tx_valid_in,
    output logic tx_ready_out
);
    import lrsd_pkg::*;
    initial begin
        hdr_valid_out = 1'b0;
        hdr_pid_out = 8'h00;
        rx_byte_out = 9'h000;
        rx_abort_out = 1'b0;
        rx_framing_err_out = 1'b0;
        tx_ready_out = 1'b0;
    end
    // Slow mode stalls every response byte after the first for one cycle
    always @(posedge core_clk_in) begin
        tx_ready_out <= (slow_in && rst_n_in && tx_valid_in) ?
                        ~tx_ready_out : 1'b1;
    end
    function automatic logic [7:0] pidf(input logic [5:0] id);
        return {~(id[1] ^ id[3] ^ id[4] ^ id[5]),
                id[0] ^ id[1] ^ id[2] ^ id[4], id};
    endfunction
    function automatic logic [7:0] cks(input logic [7:0] p,
                                       input logic [63:0] d);
        logic [8:0] s;
        s = {1'b0, p};
        for (int k = 0; k < 8; k++) begin
            s = {1'b0, s[7:0]} + {1'b0, d[8*k+:8]};
            s = {1'b0, s[7:0]} + {8'h00, s[8]};
        end
        return ~s[7:0];
    endfunction
    task automatic header(input logic [7:0] pid);
        @(posedge core_clk_in);
        hdr_valid_out <= 1'b1;
        hdr_pid_out <= pid;
        @(posedge core_clk_in);
        hdr_valid_out <= 1'b0;
        hdr_pid_out <= ~pid;
    endtask
    task automatic put(input logic [7:0] b);
        @(posedge core_clk_in);
        rx_byte_out <= {1'b1, b};
        @(posedge core_clk_in);
        rx_byte_out <= {1'b0, ~b};
    endtask
    task automatic frame(input logic [7:0] pid, input logic [63:0] d);
        header(pid);
        for (int k = 0; k < 8; k++) put(d[8*k+:8]);
        put(cks(pid, d));
    endtask
    task automatic abort_frame();
        @(posedge core_clk_in);
        rx_abort_out <= 1'b1;
        @(posedge core_clk_in);
        rx_abort_out <= 1'b0;
    endtask
    task automatic ferr();
        @(posedge core_clk_in);
        rx_framing_err_out <= 1'b1;
        @(posedge core_clk_in);
        rx_framing_err_out <= 1'b0;
    endtask
endmodule

/* File: verification/lin_relay_status_decoder_tb.sv */
`timescale 1ns/1ps
module lin_relay_status_decoder_tb;
    import lrsd_pkg::*;
    logic core_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, seed = 32'h19A0;
    logic pready, pslverr, hv, rab, rfe, txv, txr, irq;
    logic [7:0] hp, txb, chon;
    logic [7:0] node_address = 8'h62;
    logic [1:0] pos = 2'h1;
    lrsd_byte_s rxb;
    lrsd_fault_s fault = '0;
    logic [32:0] aq[$];
    logic [7:0] tq[$];
    logic [1:0] st[8];
    int fail_count = 0, cmp_count = 0;
    wire logic [5:0] sid = {node_address[3:1], STAT_SUB + {1'b0, pos}};
    wire logic [5:0] cid = {node_address[3:1], CTRL_SUB};
    always #10 core_clk_in = ~core_clk_in;
    lrsd_decoder dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .apb_psel_in(psel), .apb_penable_in(penable), .apb_pwrite_in(pwrite),
        .apb_paddr_in(paddr), .apb_pwdata_in(pwdata), .apb_pready_out(pready),
        .apb_prdata_out(prdata), .apb_pslverr_out(pslverr),
        .node_address_in(node_address), .slave_position_select_in(pos),
        .hdr_valid_in(hv), .hdr_pid_in(hp), .rx_byte_in(rxb),
        .rx_abort_in(rab), .rx_framing_err_in(rfe), .tx_valid_out(txv),
        .tx_byte_out(txb), .tx_ready_in(txr), .fault_in(fault),
        .channel_on_out(chon), .irq_out(irq));
    lrsd_lin_master m (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .slow_in(slow), .hdr_valid_out(hv), .hdr_pid_out(hp),
        .rx_byte_out(rxb), .rx_abort_out(rab), .rx_framing_err_out(rfe),
        .tx_valid_in(txv), .tx_ready_out(txr));
    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [32:0] g, input logic [32:0] e);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Monitors: each result takes the oldest note
    always @(posedge core_clk_in) begin
        if (txv && txr)
            chk(txb, tq.size() > 0 ? tq.pop_front() : 8'hXX);
        if (psel && penable && pready && !pwrite)
            chk({pslverr, prdata}, aq.size() > 0 ? aq.pop_front() : 'x);
    end
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input logic [32:0] e);
        int n;
        n = 0;
        @(posedge core_clk_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        if (!wr) aq.push_back(e);
        @(posedge core_clk_in);
        penable <= 1'b1;
        do begin
            @(posedge core_clk_in);
            n++;
        end while (pready !== 1'b1 && n < 50);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            fail_count++;
            summarize();
        end
    endtask
    task automatic drain();
        int n;
        n = 0;
        while ((tq.size() != 0 || txv) && n < 400) begin
            @(posedge core_clk_in);
            n++;
        end
        if (n >= 400) begin
            fail_count++;
            summarize();
        end
    endtask
    task automatic status(input logic [2:0] err, input logic [4:0] app);
        logic [63:0] d;
        d = {40'h0, st[7], st[6], st[5], st[4], st[3], st[2], st[1], st[0],
             err, app};
        for (int k = 0; k < 8; k++) tq.push_back(d[8*k+:8]);
        tq.push_back(m.cks(m.pidf(sid), d));
        m.header(m.pidf(sid));
        drain();
    endtask
    task automatic silent(input logic [7:0] pid);
        m.header(pid);
        repeat (2) @(posedge core_clk_in);
        chk(txv, 1'b0);
    endtask
    task automatic restart(input logic [7:0] a, input logic [1:0] p);
        rst_n_in <= 1'b0;
        node_address <= a;
        pos <= p;
        fault <= '0;
        repeat (2) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        repeat (2) @(posedge core_clk_in);
        for (int i = 0; i < 8; i++) st[i] = ST_OFF;
    endtask
    task automatic ctrl(input logic [5:0] id, input logic [63:0] d,
                        input logic hit);
        logic [15:0] c;
        logic [7:0] e;
        c = {d[8*(2*pos+1)+:8], d[8*(2*pos)+:8]};
        m.frame(m.pidf(id), d);
        for (int i = 0; i < 8; i++) begin
            if (hit && c[2*i+:2] == CMD_OFF) st[i] = ST_OFF;
            if (hit && c[2*i+:2] == CMD_ON) st[i] = ST_ON;
            e[i] = (st[i] == ST_ON);
        end
        repeat (2) @(posedge core_clk_in);
        chk(chon, e);
    endtask
    initial begin
        repeat (90000) @(posedge core_clk_in);
        fail_count++;
        summarize();
    end
    initial begin
        for (int i = 0; i < 8; i++) st[i] = ST_OFF;
        repeat (2) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        repeat (2) @(posedge core_clk_in);
        apb(1'b0, REG_CTRL, 32'h0, {32'h0, CTRL_RESP_EN_RST});
        apb(1'b0, REG_IRQ_MASK, 32'h0, {29'h0, IRQ_MASK_RST});
        apb(1'b0, 12'h020, 32'h0, {1'b1, 32'h0});
        apb(1'b1, REG_IRQ_STAT, 32'hF, 33'h0);
        apb(1'b1, REG_IRQ_MASK, 32'h1 << IRQ_STAT, 33'h0);
        status(ERR_RESET, APP_NONE);
        repeat (2) @(posedge core_clk_in);
        chk(irq, 1'b1);
        apb(1'b1, REG_IRQ_STAT, 32'h1 << IRQ_STAT, 33'h0);
        repeat (2) @(posedge core_clk_in);
        chk(irq, 1'b0);
        apb(1'b0, REG_INFO, 32'h0, {15'h0, pos, node_address, 8'h00});
        apb(1'b1, REG_CTRL, 32'h0, 33'h0);
        silent(m.pidf(sid));
        apb(1'b1, REG_CTRL, 32'h1, 33'h0);
        status(ERR_NONE, APP_NONE);
        slow <= 1'b1;
        repeat (6) ctrl(cid, {xs(), xs()}, 1'b1);
        status(ERR_NONE, APP_NONE);
        m.header(m.pidf(cid));
        m.put(8'h00);
        m.abort_frame();
        status(ERR_DATA, APP_NONE);
        m.header(m.pidf(cid));
        repeat (9) m.put(8'hAA);
        status(ERR_CKSUM, APP_NONE);
        ctrl({3'h0, CTRL_SUB}, {4{16'hAAAA}}, 1'b0);
        m.ferr();
        m.header(m.pidf(6'h3E) ^ 8'h80);
        status(ERR_PARITY, APP_NONE);
        m.ferr();
        status(ERR_FRAME, APP_NONE);
        status(ERR_NONE, APP_NONE);
        ctrl(cid, {4{16'hAAAA}}, 1'b1);
        @(posedge core_clk_in);
        fault <= '{overcurrent: 8'h08, local_ot: 2'h2, default: '0};
        st[3] = ST_LATCHED;
        st[7] = ST_LATCHED;
        repeat (3) @(posedge core_clk_in);
        status(ERR_NONE, APP_OUT48);
        fault <= '0;
        ctrl(cid, {4{16'h5555}}, 1'b1);
        fault <= '{open_load: 2'h3, default: '0};
        st[3] = ST_OPEN;
        st[7] = ST_OPEN;
        repeat (3) @(posedge core_clk_in);
        status(ERR_NONE, APP_NONE);
        fault <= '{global_tsd: 1'b1, default: '0};
        st[3] = ST_OFF;
        st[7] = ST_OFF;
        repeat (3) @(posedge core_clk_in);
        status(ERR_NONE, APP_GLOBAL_TSD);
        restart(8'h6C, 2'h3);
        ctrl(cid, {xs(), xs()}, 1'b1);
        status(ERR_RESET, APP_NONE);
        restart(8'h6E, 2'h0);
        ctrl(cid, {4{16'hAAAA}}, 1'b0);
        silent(m.pidf(sid));
        summarize();
    end
endmodule
